// file: hw/lofs_consts.vh
`ifndef LOFS_CONSTS_VH
`define LOFS_CONSTS_VH

// ****************************************
// Register offsets (word index on the port)
// ****************************************
`define LOFS_ADDR_W 4
`define LOFS_OFF_SEL_LO 4'h0
`define LOFS_OFF_SEL_HI 4'h1
`define LOFS_OFF_MID_THR 4'h2
`define LOFS_OFF_DIR_THR 4'h3
`define LOFS_OFF_BRK_TIME 4'h4
`define LOFS_OFF_CON_TIME 4'h5
`define LOFS_OFF_STATUS 4'h6
`define LOFS_OFF_ACTIVE 4'h7

// ****************************************
// Function select codes
// ****************************************
`define LOFS_SEL_W 5
`define LOFS_FN_NONE 5'h00
`define LOFS_FN_ALARM 5'h01
`define LOFS_FN_ALARM_FLT 5'h02
`define LOFS_FN_FAULT 5'h03
`define LOFS_FN_MID_SPEED 5'h04
`define LOFS_FN_AUTO_BRAKE 5'h05
`define LOFS_FN_BRK_ALARM 5'h06
`define LOFS_FN_BRK_SW_FLT 5'h07
`define LOFS_FN_BRK_HOLD 5'h08
`define LOFS_FN_BRK_PICK 5'h09
`define LOFS_FN_HOLD_FLT 5'h0a
`define LOFS_FN_PICK_FLT 5'h0b
`define LOFS_FN_GOING_DN 5'h0c
`define LOFS_FN_GOING_UP 5'h0d
`define LOFS_FN_CHARGE_FLT 5'h0e
`define LOFS_FN_CLOSE_CON 5'h0f
`define LOFS_FN_CON_FLT 5'h10
`define LOFS_FN_CURR_FLT 5'h11
`define LOFS_FN_DRV_OVL 5'h12
`define LOFS_FN_ENC_FLT 5'h13
`define LOFS_FN_FAN_ON 5'h14
`define LOFS_FN_FAN_ALARM 5'h15
`define LOFS_FN_RESET_REQ 5'h16

// ****************************************
// Reset values of the selects
// ****************************************
`define LOFS_RST_SEL_LO 32'h0000_0000
`define LOFS_RST_SEL_HI 32'h0000_0000

// ****************************************
// Timing (counts in 10 ns clock cycles)
// ****************************************
`define LOFS_CNT_W 32
`define LOFS_RST_BRK_TIME 32'h0000_0064
`define LOFS_RST_CON_TIME 32'h0000_0064

`endif

// file: hw/lofs_selector.v
// Notes on behaviour
// - Four logic outputs, each own function select
// - Two relay coils, same function list
// - User LED with its own function select
// - Alarm choice follows any declared alarm
// - Alarm-or-fault choice asserts on either
// - Fault choice follows declared fault
// - Mid-speed choice: speed magnitude above threshold
// - Auto brake choice follows brake controller
// - Resistor overcurrent while running gives alarm
// - Resistor overcurrent while stopped gives fault
// - Brake hold follows pick confirmation input
// - Brake pick follows regulator release
// - Hold command/feedback mismatch beyond time
// - Pick command/feedback mismatch beyond time
// - Direction choices: signed speed beyond threshold
// - Charging fault: bus or contactor failure
// - Close contactor: run, enable, init, no fault
// - Contactor command/feedback mismatch at timeout
// - Current regulation fault mirrors mismatch flag
// - Encoder, overload, fan failure mirror flags
// - Fan indicator follows cooling fan state
// - Reset request: automatic reset request gated by error clear source
// - No-function choice stays deasserted always
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "lofs_consts.vh"

module lofs_selector #(
  parameter SPD_W = 16
)(
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [`LOFS_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire alarm_i,
  input wire fault_i,
  input wire signed [SPD_W-1:0] speed_i,
  input wire auto_brake_i,
  input wire dbr_overcurrent_i,
  input wire running_i,
  input wire brake_confirm_i,
  input wire regulator_release_sel_i,
  input wire brake_hold_cmd_i,
  input wire brake_feedback_i,
  input wire charge_fault_i,
  input wire run_cmd_i,
  input wire drive_enable_i,
  input wire init_done_i,
  input wire contactor_feedback_i,
  input wire curr_mismatch_i,
  input wire drv_overload_i,
  input wire encoder_fault_i,
  input wire fan_on_i,
  input wire fan_fail_i,
  input wire reset_request_i,
  input wire error_clear_source_i,
  output reg [3:0] logic_out_o,
  output reg [1:0] relay_coil_o,
  output reg user_led_o
);

  localparam N_OUT = 7;

  // ****************************************
  // Registers
  // ****************************************
  reg [`LOFS_SEL_W-1:0] sel_r [0:N_OUT-1];
  reg [`LOFS_SEL_W-1:0] pend_r [0:N_OUT-1];
  reg pend_vld_r;
  reg [SPD_W-1:0] mid_thr_r;
  reg [SPD_W-1:0] dir_thr_r;
  reg [`LOFS_CNT_W-1:0] brk_time_r;
  reg [`LOFS_CNT_W-1:0] con_time_r;
  reg [`LOFS_CNT_W-1:0] hold_cnt_r;
  reg [`LOFS_CNT_W-1:0] pick_cnt_r;
  reg [`LOFS_CNT_W-1:0] con_cnt_r;
  reg hold_flt_r;
  reg pick_flt_r;
  reg con_flt_r;
  reg close_con_r;

  // ****************************************
  // Conditions
  // ****************************************
  wire signed [SPD_W:0] spd_ext = {speed_i[SPD_W-1], speed_i};
  wire signed [SPD_W:0] mid_ext = {1'b0, mid_thr_r};
  wire signed [SPD_W:0] dir_ext = {1'b0, dir_thr_r};
  // Extra sign bit keeps the most negative speed from wrapping
  function beyond;
    input signed [SPD_W:0] val;
    input signed [SPD_W:0] thr;
    begin
      beyond = val > thr;
    end
  endfunction

  wire mid_spd = beyond(spd_ext, mid_ext) || beyond(-spd_ext, mid_ext);
  wire going_up = beyond(spd_ext, dir_ext);
  wire going_dn = beyond(-spd_ext, dir_ext);
  wire close_con = run_cmd_i & drive_enable_i & init_done_i & ~fault_i;
  wire pick_cmd = regulator_release_sel_i;

  function cond_of;
    input [`LOFS_SEL_W-1:0] sel;
    begin
      case (sel)
        `LOFS_FN_ALARM: cond_of = alarm_i;
        `LOFS_FN_ALARM_FLT: cond_of = alarm_i | fault_i;
        `LOFS_FN_FAULT: cond_of = fault_i;
        `LOFS_FN_MID_SPEED: cond_of = mid_spd;
        `LOFS_FN_AUTO_BRAKE: cond_of = auto_brake_i;
        `LOFS_FN_BRK_ALARM: cond_of = dbr_overcurrent_i & running_i;
        `LOFS_FN_BRK_SW_FLT: cond_of = dbr_overcurrent_i & ~running_i;
        `LOFS_FN_BRK_HOLD: cond_of = brake_confirm_i;
        `LOFS_FN_BRK_PICK: cond_of = pick_cmd;
        `LOFS_FN_HOLD_FLT: cond_of = hold_flt_r;
        `LOFS_FN_PICK_FLT: cond_of = pick_flt_r;
        `LOFS_FN_GOING_DN: cond_of = going_dn;
        `LOFS_FN_GOING_UP: cond_of = going_up;
        `LOFS_FN_CHARGE_FLT: cond_of = charge_fault_i;
        `LOFS_FN_CLOSE_CON: cond_of = close_con;
        `LOFS_FN_CON_FLT: cond_of = con_flt_r;
        `LOFS_FN_CURR_FLT: cond_of = curr_mismatch_i;
        `LOFS_FN_DRV_OVL: cond_of = drv_overload_i;
        `LOFS_FN_ENC_FLT: cond_of = encoder_fault_i;
        `LOFS_FN_FAN_ALARM: cond_of = fan_fail_i;
        `LOFS_FN_FAN_ON: cond_of = fan_on_i;
        `LOFS_FN_RESET_REQ: cond_of = reset_request_i & error_clear_source_i;
        default: cond_of = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Mismatch timers
  // ****************************************
  // Registered so the contactor timer compares a settled command
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      close_con_r <= 1'b0;
    else
      close_con_r <= close_con;
  end

  // Counters stop at the limit, so a long mismatch never wraps
  // hold mismatch timer
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      hold_cnt_r <= {`LOFS_CNT_W{1'b0}};
      hold_flt_r <= 1'b0;
    end
    else if (brake_hold_cmd_i == brake_feedback_i)
    begin
      hold_cnt_r <= {`LOFS_CNT_W{1'b0}};
      hold_flt_r <= 1'b0;
    end
    else if (hold_cnt_r < brk_time_r)
      hold_cnt_r <= hold_cnt_r + 1'b1;
    else
      hold_flt_r <= 1'b1;
  end

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      pick_cnt_r <= {`LOFS_CNT_W{1'b0}};
      pick_flt_r <= 1'b0;
    end
    else if (pick_cmd == brake_feedback_i)
    begin
      pick_cnt_r <= {`LOFS_CNT_W{1'b0}};
      pick_flt_r <= 1'b0;
    end
    else if (pick_cnt_r < brk_time_r)
      pick_cnt_r <= pick_cnt_r + 1'b1;
    else
      pick_flt_r <= 1'b1;
  end

  // ****************************************
  // Contactor timer
  // ****************************************
  // contactor timeout
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      con_cnt_r <= {`LOFS_CNT_W{1'b0}};
      con_flt_r <= 1'b0;
    end
    else if (close_con_r == contactor_feedback_i)
    begin
      con_cnt_r <= {`LOFS_CNT_W{1'b0}};
      con_flt_r <= 1'b0;
    end
    else if (con_cnt_r < con_time_r)
      con_cnt_r <= con_cnt_r + 1'b1;
    else
      con_flt_r <= 1'b1;
  end

  // ****************************************
  // Select lanes
  // ****************************************
  wire [`LOFS_SEL_W*N_OUT-1:0] sel_flat;
  wire [N_OUT-1:0] cond_vec;
  wire sel_wr = wr_i && (addr_i == `LOFS_OFF_SEL_LO || addr_i == `LOFS_OFF_SEL_HI);
  integer j;

  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1)
    begin : g_out
      assign sel_flat[g*`LOFS_SEL_W +: `LOFS_SEL_W] = sel_r[g];
      assign cond_vec[g] = cond_of(sel_r[g]);
    end
  endgenerate

  // ****************************************
  // Select staging
  // ****************************************
  // One process owns both arrays, so each has a single driver
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      for (j = 0; j < N_OUT; j = j + 1)
      begin
        sel_r[j] <= {`LOFS_SEL_W{1'b0}};
        pend_r[j] <= {`LOFS_SEL_W{1'b0}};
      end
    end
    else
    begin
      for (j = 0; j < N_OUT; j = j + 1)
      begin
        if (wr_i && addr_i == ((j < 4) ? `LOFS_OFF_SEL_LO : `LOFS_OFF_SEL_HI))
          pend_r[j] <= wdata_i[(j % 4)*8 +: `LOFS_SEL_W];
        // apply only while stopped; LED not locked
        if (j == 6 && wr_i && addr_i == `LOFS_OFF_SEL_HI)
          sel_r[j] <= wdata_i[16 +: `LOFS_SEL_W];
        else if (pend_vld_r && !running_i)
          sel_r[j] <= pend_r[j];
      end
    end
  end

  // ****************************************
  // Pending select flag
  // ****************************************
  // A write in the same cycle wins over the clear
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      pend_vld_r <= 1'b0;
    else if (sel_wr)
      pend_vld_r <= 1'b1;
    else if (!running_i)
      pend_vld_r <= 1'b0;
  end

  // ****************************************
  // Thresholds and times
  // ****************************************
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      mid_thr_r <= {SPD_W{1'b0}};
      dir_thr_r <= {SPD_W{1'b0}};
      brk_time_r <= `LOFS_RST_BRK_TIME;
      con_time_r <= `LOFS_RST_CON_TIME;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `LOFS_OFF_MID_THR: mid_thr_r <= wdata_i[SPD_W-1:0];
        `LOFS_OFF_DIR_THR: dir_thr_r <= wdata_i[SPD_W-1:0];
        `LOFS_OFF_BRK_TIME: brk_time_r <= wdata_i;
        `LOFS_OFF_CON_TIME: con_time_r <= wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Byte-wide lanes, code in the low five bits of each
  wire [31:0] sel_lo_word = {3'h0, sel_flat[19:15], 3'h0, sel_flat[14:10],
                             3'h0, sel_flat[9:5], 3'h0, sel_flat[4:0]};
  wire [31:0] sel_hi_word = {11'h000, sel_flat[34:30], 3'h0, sel_flat[29:25],
                             3'h0, sel_flat[24:20]};
  wire [31:0] status_word = {25'h000_0000, pend_vld_r, running_i, close_con_r,
                             con_flt_r, pick_flt_r, hold_flt_r, 1'b0};
  wire [31:0] active_word = {25'h000_0000, user_led_o, relay_coil_o, logic_out_o};
  wire [31:0] mid_word = {{(32-SPD_W){1'b0}}, mid_thr_r};
  wire [31:0] dir_word = {{(32-SPD_W){1'b0}}, dir_thr_r};
  reg [31:0] rdata_nxt;

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        `LOFS_OFF_SEL_LO: rdata_nxt = sel_lo_word;
        `LOFS_OFF_SEL_HI: rdata_nxt = sel_hi_word;
        `LOFS_OFF_MID_THR: rdata_nxt = mid_word;
        `LOFS_OFF_DIR_THR: rdata_nxt = dir_word;
        `LOFS_OFF_BRK_TIME: rdata_nxt = brk_time_r;
        `LOFS_OFF_CON_TIME: rdata_nxt = con_time_r;
        `LOFS_OFF_STATUS: rdata_nxt = status_word;
        `LOFS_OFF_ACTIVE: rdata_nxt = active_word;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Zero outside the read cycle, so no stale word lingers
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= rdata_nxt;
  end

  // ****************************************
  // Terminal outputs
  // ****************************************
  // One cycle from condition to terminal for every choice
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      logic_out_o <= 4'h0;
      relay_coil_o <= 2'h0;
      user_led_o <= 1'b0;
    end
    else
    begin
      logic_out_o <= cond_vec[3:0];
      relay_coil_o <= cond_vec[5:4];
      user_led_o <= cond_vec[6];
    end
  end

endmodule

// file: testbench/lofs_ctrl_model.sv
`timescale 1ns/10ps
// Controller side latches the terminals once a clock, as its inputs would
module lofs_ctrl_model (
  input wire mclk_i,
  input wire [3:0] logic_out_i,
  input wire [1:0] relay_coil_i,
  input wire user_led_i,
  output reg [6:0] seen_o
);
  always @(posedge mclk_i)
    seen_o <= {user_led_i, relay_coil_i, logic_out_i};
endmodule

// file: testbench/lofs_selector_props.sv
`timescale 1ns/10ps
`include "lofs_consts.vh"
module lofs_chk (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [`LOFS_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire [3:0] logic_out_o,
  input wire [1:0] relay_coil_o,
  input wire user_led_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  reg sel_wr_r;
  reg tm_wr_r;
  // ****************************************
  // Write history since reset
  // ****************************************
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sel_wr_r <= 1'b0;
      tm_wr_r <= 1'b0;
    end
    else
    begin
      sel_wr_r <= sel_wr_r | (wr_i & (addr_i < 4'h2));
      tm_wr_r <= tm_wr_r | (wr_i & (addr_i[3:1] == 3'h2));
    end
  end
  chk_reset_outs_low: assert property (disable iff (1'b0) sys_rst_i |=>
    (logic_out_o == 4'h0) && (relay_coil_o == 2'h0) && !user_led_o) else $error("outputs not low after reset");
  chk_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0000_0000) else $error("read data not idle");
  chk_unmapped_reads: assert property (rd_i && addr_i[3] |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_default_none: assert property (!sel_wr_r |-> !user_led_o && (logic_out_o == 4'h0)
    && (relay_coil_o == 2'h0)) else $error("output active with no function");
  chk_sel_reset_val: assert property (rd_i && (addr_i < 4'h2) && !sel_wr_r |=>
    rdata_o == `LOFS_RST_SEL_LO) else $error("select reset value wrong");
  chk_thr_readback: assert property (wr_i && addr_i == 4'h2 ##1 rd_i && addr_i == 4'h2 |=>
    rdata_o == $past(wdata_i, 2)) else $error("threshold readback wrong");
  chk_brk_time_dflt: assert property (rd_i && addr_i == 4'h4 && !tm_wr_r |=>
    rdata_o == `LOFS_RST_BRK_TIME) else $error("brake time default wrong");
  chk_con_time_dflt: assert property (rd_i && addr_i == 4'h5 && !tm_wr_r |=>
    rdata_o == `LOFS_RST_CON_TIME) else $error("contactor time default wrong");
endmodule
bind lofs_selector lofs_chk u_lofs_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .logic_out_o(logic_out_o),
  .relay_coil_o(relay_coil_o), .user_led_o(user_led_o));

// file: testbench/lofs_selector_test.sv
`timescale 1ns/10ps
`include "lofs_consts.vh"
module lofs_selector_test;
  reg mclk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0000_0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_d = 1'b0;
  reg [20:0] c = 21'h0_0000;
  reg signed [15:0] spd = 16'h0000;
  wire [31:0] rdata;
  wire [3:0] lo_out;
  wire [1:0] rc;
  wire led;
  wire [6:0] seen;
  int n_fail = 0;
  int checks_done = 0;
  int mid, dir, k, i;
  logic [31:0] q[$];
  bit qo[$];
  logic [31:0] sl, sh, e, x;
  always #5 mclk_i = ~mclk_i;
  lofs_selector u_lofs_selector (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .alarm_i(c[0]), .fault_i(c[1]), .speed_i(spd), .auto_brake_i(c[2]),
    .dbr_overcurrent_i(c[3]), .running_i(c[4]), .brake_confirm_i(c[5]), .regulator_release_sel_i(c[6]),
    .brake_hold_cmd_i(c[7]), .brake_feedback_i(c[8]), .charge_fault_i(c[9]), .run_cmd_i(c[10]),
    .drive_enable_i(c[11]), .init_done_i(c[12]), .contactor_feedback_i(c[13]), .curr_mismatch_i(c[14]),
    .drv_overload_i(c[15]), .encoder_fault_i(c[16]), .fan_on_i(c[17]), .fan_fail_i(c[18]),
    .reset_request_i(c[19]), .error_clear_source_i(c[20]), .logic_out_o(lo_out), .relay_coil_o(rc),
    .user_led_o(led));
  lofs_ctrl_model u_lofs_ctrl_model (.mclk_i(mclk_i), .logic_out_i(lo_out), .relay_coil_i(rc),
    .user_led_i(led), .seen_o(seen));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [31:0] d, input bit o);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    q.push_back(d);
    qo.push_back(o);
  endtask
  task idle(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  // ****************************************
  // Expected level for one function code
  // ****************************************
  function logic f(input int s);
    logic cl;
    int v;
    cl = c[10] & c[11] & c[12] & !c[1];
    v = spd;
    case (s)
      1: f = c[0];
      2: f = c[0] | c[1];
      3: f = c[1];
      4: f = (v < 0 ? -v : v) > mid;
      5: f = c[2];
      6: f = c[3] & c[4];
      7: f = c[3] & !c[4];
      8: f = c[5];
      9: f = c[6];
      10: f = c[7] ^ c[8];
      11: f = c[6] ^ c[8];
      12: f = -v > dir;
      13: f = v > dir;
      14: f = c[9];
      15: f = cl;
      16: f = cl ^ c[13];
      17: f = c[14];
      18: f = c[15];
      19: f = c[16];
      20: f = c[17];
      21: f = c[18];
      22: f = c[19] & c[20];
      default: f = 1'b0;
    endcase
  endfunction
  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i)
  begin
    rd_d <= rd;
    if (rd_d && q.size() > 0)
    begin
      e = q.pop_front();
      chk("read data", e, rdata);
      if (qo.pop_front())
        chk("terminals", e, {25'h000_0000, seen});
    end
  end
  initial
  begin
    #100_000;
    n_fail++;
    conclude();
  end
  initial
  begin
    void'($urandom(81));
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (k = 0; k < 16; k++)
      if (k < 2 || k == 4 || k == 5 || k > 7)
        rd_reg(k[3:0], k == 4 ? `LOFS_RST_BRK_TIME : k == 5 ? `LOFS_RST_CON_TIME : 32'h0000_0000, 0);
    $display("reset values done");
    mid = $urandom % 20000;
    dir = $urandom % 20000;
    wr_reg(4'h2, mid);
    rd_reg(4'h2, mid, 0);
    wr_reg(4'h3, dir);
    wr_reg(4'h4, 32'h0000_0003);
    wr_reg(4'h5, 32'h0000_0003);
    idle(2);
    // Every code lands on every output over the rounds
    for (k = 0; k < 23; k++)
    begin
      c <= 21'($urandom) & 21'h1f_ffef;
      spd <= 16'($urandom);
      sl = 32'h0000_0000;
      sh = 32'h0000_0000;
      for (i = 0; i < 4; i++)
        sl[8*i +: 5] = (k + i) % 23;
      for (i = 0; i < 3; i++)
        sh[8*i +: 5] = (k + 4 + i) % 23;
      wr_reg(4'h0, sl);
      wr_reg(4'h1, sh);
      idle(2);
      c[4] <= 1'($urandom);
      idle(12);
      x = 32'h0000_0000;
      for (i = 0; i < 7; i++)
        x[i] = f((k + i) % 23);
      rd_reg(4'h7, x, 1);
      idle(2);
    end
    $display("function table done");
    // Drive stopped, or the clearing selects would stay staged
    c[4] <= 1'b0;
    wr_reg(4'h0, 32'h0000_0000);
    wr_reg(4'h1, 32'h0000_0000);
    idle(2);
    c <= 21'h0_0012;
    wr_reg(4'h0, 32'h0303_0303);
    idle(12);
    rd_reg(4'h7, 32'h0000_0000, 1);
    idle(2);
    c[4] <= 1'b0;
    idle(4);
    rd_reg(4'h7, 32'h0000_000f, 1);
    idle(3);
    $display("select staging done");
    conclude();
  end
endmodule
